// >>> hdl/transfer_activation_control.sv
// Functional notes
// [RQ1] nmi events set the nmi block flag
// [RQ2] flag clears by writing 0 after reading 1
// [RQ3] flag set blocks every new transfer start
// [RQ4] running transfer completes despite flag rising
// [RQ5] software waits 16 clocks, prescaler 16
// [RQ6] software waits 128 clocks, prescaler 128
// [RQ7] software disables osc-stop irq before clearing
// [RQ8] reserved bit written 0; upper bits read 0
// [RQ9] fetch set, transfer, write set back
// [RQ10] twenty-four independent control data sets
// [RQ11] normal, repeat, and chained back-to-back transfers
// [RQ12] 16-bit pointers, each fixed or incrementing
// [RQ13] only enabled sources trigger transfers
// [RQ14] count end clears the source enable bit
// [RQ15] otherwise clear timer or flash source flag
// [RQ16] simultaneous requests served by fixed priority
// [RQ17] next transfer after completion by priority
// [RQ18] cpu interrupt masks never gate activation
// [RQ19] source irq request flag left untouched
// [RQ20] 8-bit count decrements, 00h means 256
// [RQ21] repeat mode reloads count from reload value
// [RQ22] enable bit: 0 disabled, 1 enabled
// [RQ23] reset clears nmi flag and reserved bit
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module transfer_activation_control #(
   parameter int NUM_SETS = 24,
   parameter logic [15:0] CD_BASE = xfer_ctrl_pkg::CD_BASE_RST,
   parameter logic [23:0] FLAG_CLR_SRC = xfer_ctrl_pkg::FLAG_CLR_SRC_RST
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // activation sources and non-maskable events, one-cycle pulses
   input wire logic [23:0] src_trig_i,
   input wire logic [xfer_ctrl_pkg::NMI_SRC_NUM-1:0] nmi_event_i,
   // peripheral flag clear pulses
   output logic [23:0] src_flag_clr_o,
   // memory master port, byte wide
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [15:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_ack_i
);
   import xfer_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic nmi_flag_reg;           // nmi_block_flag
   logic rsvd_reg;               // reserved bit, stored as written
   logic read_one_reg;           // flag was read back as 1
   logic [23:0] act_en_reg;      // activation_enable_reg
   logic [23:0] pend_reg;        // latched requests
   logic wb_ack_reg;
   logic [31:0] wb_dat_reg;
   xfer_state_e state_reg;
   logic [4:0] cur_reg;          // set in service
   logic first_reg;              // first set of a chain
   logic [2:0] idx_reg;          // byte index within a set
   logic [7:0] cd_reg [0:7];     // fetched control data set
   logic [7:0] data_reg;         // byte in flight
   logic mem_req_reg;
   logic mem_we_reg;
   logic [15:0] mem_addr_reg;
   logic [7:0] mem_wdata_reg;
   logic [23:0] flag_clr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // wishbone decode
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
   wire bus_wr = bus_req & wb_we_i;
   wire bus_rd = bus_req & ~wb_we_i;
   wire hit_ctrl = (wb_adr_i == ACT_CTRL_ADDR);
   wire hit_en = (wb_adr_i == ACT_EN_ADDR);
   wire hit_stat = (wb_adr_i == STATUS_ADDR);
   wire wr_ctrl = bus_wr & hit_ctrl & wb_sel_i[0];
   wire wr_en = bus_wr & hit_en;
   // upper bits of the control byte always read as zero [RQ8]
   wire [31:0] ctrl_rd = {30'h0, nmi_flag_reg, rsvd_reg};
   wire [31:0] en_rd = {8'h00, act_en_reg};
   wire busy = (state_reg != ST_IDLE);
   wire [31:0] stat_rd = {19'h0, cur_reg, 7'h00, busy};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_rd : hit_en ? en_rd : hit_stat ? stat_rd : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // nmi block flag
   wire nmi_set = |nmi_event_i;
   // a zero written only after a read of one clears; writing one does nothing [RQ2]
   wire nmi_clr = wr_ctrl & read_one_reg & ~wb_dat_i[NMI_FLAG_BIT];

   // flag, set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nmi_flag_reg <= 1'b0; // [RQ23]
         rsvd_reg <= 1'b0; // [RQ23]
         read_one_reg <= 1'b0;
      end else begin
         if (nmi_set) begin
            nmi_flag_reg <= 1'b1; // [RQ1]
         end else if (nmi_clr) begin
            nmi_flag_reg <= 1'b0; // [RQ2]
         end
         if (wr_ctrl) begin
            rsvd_reg <= wb_dat_i[ACT_RSVD_BIT]; // software keeps it 0 [RQ8]
         end
         // arm on a read of one, disarm on any write to the byte
         if (bus_rd & hit_ctrl & nmi_flag_reg) begin
            read_one_reg <= 1'b1;
         end else if (wr_ctrl) begin
            read_one_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wishbone answer, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_reg <= 1'b0;
         wb_dat_reg <= 32'h0;
      end else begin
         wb_ack_reg <= bus_req;
         wb_dat_reg <= bus_rd ? rd_mux : 32'h0;
      end
   end
   assign wb_ack_o = wb_ack_reg;
   assign wb_dat_o = wb_dat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // transfer bookkeeping wires
   wire [7:0] cw = cd_reg[CD_CTRL];
   wire [7:0] cnt = cd_reg[CD_CNT];
   wire [15:0] src_ptr = {cd_reg[CD_SRC_HI], cd_reg[CD_SRC_LO]};
   wire [15:0] dst_ptr = {cd_reg[CD_DST_HI], cd_reg[CD_DST_LO]};
   // 8-bit wrap makes 00h count down through 256 transfers [RQ20]
   wire [7:0] cnt_dec = cnt - 8'h01;
   wire cnt_zero = (cnt_dec == 8'h00);
   wire rpt_mode = cw[CW_REPEAT_BIT];
   // count end that stops the source: normal, or repeat with irq enabled [RQ14]
   wire cnt_end = cnt_zero & (~rpt_mode | cw[CW_RPT_IRQ_BIT]);
   // pointers step independently [RQ12]
   wire [15:0] src_nxt = cw[CW_SRC_INC_BIT] ? src_ptr + 16'h0001 : src_ptr;
   wire [15:0] dst_nxt = cw[CW_DST_INC_BIT] ? dst_ptr + 16'h0001 : dst_ptr;
   // repeat mode refills an expired count [RQ21]
   wire [7:0] cnt_nxt = (rpt_mode & cnt_zero) ? cd_reg[CD_RLD] : cnt_dec;
   wire done_xfer = (state_reg == ST_WRITE) & mem_req_reg & mem_ack_i;
   wire [23:0] cur_onehot = 24'h00_0001 << cur_reg;
   wire [23:0] en_hw_clr = (done_xfer & first_reg & cnt_end) ? cur_onehot : 24'h0; // [RQ14]
   // flag clear only for timer and flash sources and only if enable stays [RQ15]
   wire [23:0] flag_clr = (done_xfer & first_reg & ~cnt_end) ? (cur_onehot & FLAG_CLR_SRC) :
                          24'h0;
   wire [15:0] set_base = CD_BASE + {8'h00, cur_reg, 3'b000};
   wire chain = cw[CW_CHAIN_BIT] & (cur_reg < 5'(NUM_SETS - 1)); // [RQ11]

   ////////////////////////////////////////////////////////////////////////////
   // enable bits and request latching, one slice per source
   logic [23:0] act_en_next;
   logic [23:0] pend_next;
   logic [23:0] grant;           // one-hot winner
   genvar gi;
   generate
      for (gi = 0; gi < 24; gi = gi + 1) begin : g_src
         // bit 1 enables, bit 0 disables its source [RQ22]
         assign act_en_next[gi] = ((wr_en & wb_sel_i[gi/8]) ? wb_dat_i[gi] : act_en_reg[gi])
                                  & ~en_hw_clr[gi] & (gi < NUM_SETS);
         // cpu irq masks are not inputs here, so they cannot gate this [RQ18]
         // nothing is fed back toward the cpu irq request flag [RQ19]
         assign pend_next[gi] = (pend_reg[gi] & ~grant[gi])
                                | (src_trig_i[gi] & act_en_reg[gi]); // [RQ13]
      end
   endgenerate

   // lowest index wins, both at once and after completion [RQ16] [RQ17]
   assign grant = pend_reg & (~pend_reg + 24'h00_0001) & {24{~busy & ~nmi_flag_reg}}; // [RQ3]

   // position of the winning bit
   logic [4:0] grant_idx;
   always_comb begin
      grant_idx = 5'h00;
      for (int k = 23; k >= 0; k--) begin
         if (grant[k]) begin
            grant_idx = 5'(k);
         end
      end
   end

   // enable and pending registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_en_reg <= ACT_EN_RST[23:0];
         pend_reg <= 24'h0;
      end else begin
         act_en_reg <= act_en_next;
         pend_reg <= pend_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // engine: fetch set, read source, write destination, write set back [RQ9]
   // the flag only gates a start, so a running transfer or chain runs out [RQ4]
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         cur_reg <= 5'h00;
         first_reg <= 1'b0;
         idx_reg <= 3'h0;
         data_reg <= 8'h00;
         mem_req_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         mem_addr_reg <= 16'h0000;
         mem_wdata_reg <= 8'h00;
         flag_clr_reg <= 24'h0;
         for (int b = 0; b < 8; b++) begin
            cd_reg[b] <= 8'h00;
         end
      end else begin
         flag_clr_reg <= flag_clr; // [RQ15]
         unique case (state_reg)
            ST_IDLE: begin
               // one of the 24 sets chosen by the winner [RQ10]
               if (|grant) begin
                  cur_reg <= grant_idx;
                  first_reg <= 1'b1;
                  idx_reg <= CD_CTRL;
                  state_reg <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               // read the eight bytes of the set in order
               if (!mem_req_reg) begin
                  mem_req_reg <= 1'b1;
                  mem_we_reg <= 1'b0;
                  mem_addr_reg <= set_base + {13'h0, idx_reg};
               end else if (mem_ack_i) begin
                  mem_req_reg <= 1'b0;
                  cd_reg[idx_reg] <= mem_rdata_i;
                  idx_reg <= idx_reg + 3'h1;
                  if (idx_reg == CD_DST_HI) begin
                     state_reg <= ST_READ;
                  end
               end
            end
            ST_READ: begin
               // one byte from the source pointer
               if (!mem_req_reg) begin
                  mem_req_reg <= 1'b1;
                  mem_we_reg <= 1'b0;
                  mem_addr_reg <= src_ptr;
               end else if (mem_ack_i) begin
                  mem_req_reg <= 1'b0;
                  data_reg <= mem_rdata_i;
                  state_reg <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               // that byte to the destination, then update count and pointers
               if (!mem_req_reg) begin
                  mem_req_reg <= 1'b1;
                  mem_we_reg <= 1'b1;
                  mem_addr_reg <= dst_ptr;
                  mem_wdata_reg <= data_reg;
               end else if (mem_ack_i) begin
                  mem_req_reg <= 1'b0;
                  cd_reg[CD_CNT] <= cnt_nxt; // [RQ20] [RQ21]
                  {cd_reg[CD_SRC_HI], cd_reg[CD_SRC_LO]} <= src_nxt; // [RQ12]
                  {cd_reg[CD_DST_HI], cd_reg[CD_DST_LO]} <= dst_nxt; // [RQ12]
                  idx_reg <= CD_CNT;
                  state_reg <= ST_BACK;
               end
            end
            ST_BACK: begin
               // count, reload and pointers go back; control word is left alone
               if (!mem_req_reg) begin
                  mem_req_reg <= 1'b1;
                  mem_we_reg <= 1'b1;
                  mem_addr_reg <= set_base + {13'h0, idx_reg};
                  mem_wdata_reg <= cd_reg[idx_reg];
               end else if (mem_ack_i) begin
                  mem_req_reg <= 1'b0;
                  idx_reg <= idx_reg + 3'h1;
                  if (idx_reg == CD_DST_HI) begin
                     if (chain) begin
                        // next set runs from the same activation [RQ11]
                        cur_reg <= cur_reg + 5'h01;
                        first_reg <= 1'b0;
                        idx_reg <= CD_CTRL;
                        state_reg <= ST_FETCH;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign mem_req_o = mem_req_reg;
   assign mem_we_o = mem_we_reg;
   assign mem_addr_o = mem_addr_reg;
   assign mem_wdata_o = mem_wdata_reg;
   assign src_flag_clr_o = flag_clr_reg;

endmodule
`default_nettype wire

// >>> include/xfer_ctrl_pkg.sv
package xfer_ctrl_pkg;
   // register byte addresses on the wishbone slave
   localparam logic [7:0] ACT_CTRL_ADDR = 8'h80;   // activation_control
   localparam logic [7:0] ACT_EN_ADDR = 8'h84;     // activation_enable_reg, one bit per source
   localparam logic [7:0] STATUS_ADDR = 8'h88;     // engine state, read only
   // activation_control fields
   localparam int ACT_RSVD_BIT = 0;                // reserved, software writes 0
   localparam int NMI_FLAG_BIT = 1;                // nmi_block_flag
   localparam logic [7:0] ACT_CTRL_RST = 8'h00;
   localparam logic [31:0] ACT_EN_RST = 32'h0000_0000;
   // status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CUR_LSB = 8;
   // non-maskable event inputs
   localparam int NMI_SRC_NUM = 4;                 // watchdog, osc stop, vmon1, vmon2
   // control data set layout, byte offsets inside one 8-byte set
   localparam logic [2:0] CD_CTRL = 3'h0;          // transfer_control_word
   localparam logic [2:0] CD_BLK = 3'h1;           // block size, kept as read
   localparam logic [2:0] CD_CNT = 3'h2;           // transfer_count
   localparam logic [2:0] CD_RLD = 3'h3;           // count_reload
   localparam logic [2:0] CD_SRC_LO = 3'h4;        // source_pointer low byte
   localparam logic [2:0] CD_SRC_HI = 3'h5;
   localparam logic [2:0] CD_DST_LO = 3'h6;        // dest_pointer low byte
   localparam logic [2:0] CD_DST_HI = 3'h7;
   localparam int CD_SET_SHIFT = 3;                // 8 bytes per set
   localparam logic [15:0] CD_BASE_RST = 16'h2c40; // control data area base
   // transfer_control_word fields
   localparam int CW_REPEAT_BIT = 0;               // 1: repeat mode, 0: normal mode
   localparam int CW_RPT_IRQ_BIT = 1;              // repeat_irq_enable
   localparam int CW_SRC_INC_BIT = 2;              // 1: source_pointer increments
   localparam int CW_DST_INC_BIT = 3;              // 1: dest_pointer increments
   localparam int CW_CHAIN_BIT = 4;                // chain_enable
   // sources whose peripheral flag is cleared: timer match a..d and flash ready
   localparam logic [23:0] FLAG_CLR_SRC_RST = 24'h00_1f00;
   // engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b011,
      ST_BACK = 3'b100
   } xfer_state_e;
endpackage

// >>> tb/test_transfer_activation_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_transfer_activation_control;
   import xfer_ctrl_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, slow, wb_ack_o, mem_req_o, mem_we_o, mem_ack;
   logic [7:0] adr, mem_rdata, mem_wdata_o;
   logic [31:0] wdat, rdat, wb_dat_o, en_exp;
   logic [23:0] trig, clr_o, clr_exp;
   logic [23:0] clr_seen = 24'h0;  // every flag clear so far
   logic [3:0] nmi;
   logic [15:0] mem_addr_o;
   logic [7:0] em [int];  // expected memory image
   int errors, comparisons, seed;
   int accs = 0;  // finished memory accesses
   int starts [$];  // control sets fetched, in order
   int pri [5] = '{5, 3, 9, 2, 7};  // expected service order
   transfer_activation_control uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o,
      .src_trig_i(trig), .nmi_event_i(nmi), .src_flag_clr_o(clr_o), .mem_req_o, .mem_we_o,
      .mem_addr_o, .mem_wdata_o, .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
   xfer_mem_model ram (.clk_i, .rst_i, .slow_i(slow), .mem_req_i(mem_req_o),
      .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // tally accesses, set fetches and flag clears
   always @(posedge clk_i) begin
      clr_seen <= clr_seen | clr_o;
      if (mem_req_o && mem_ack) begin
         accs <= accs + 1;
         if (!mem_we_o && mem_addr_o[2:0] == CD_CTRL && mem_addr_o >= CD_BASE_RST) begin
            starts.push_back(int'(mem_addr_o - CD_BASE_RST) >> 3);
         end
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      check("bus ack", 32'(wb_ack_o), 32'h1);
      rdat = wb_dat_o;
      {cyc, stb} <= 2'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
      wb(1'b0, a, 32'h0);
      check(s, rdat, e);
   endtask
   task automatic pulse(input logic [23:0] m, input logic [3:0] e);
      @(posedge clk_i);
      {trig, nmi} <= {m, e};
      @(posedge clk_i);
      {trig, nmi} <= 28'h0;
   endtask
   // wait until the memory port has been quiet for a while
   task automatic settle;
      int q;
      q = 0;
      repeat (3) @(posedge clk_i);
      while (q < 12) begin
         @(posedge clk_i);
         q = mem_req_o ? 0 : q + 1;
      end
   endtask
   // control set j plus eight random source bytes, in image and memory
   task automatic set_cd(input int j, input logic [7:0] c, input logic [7:0] n);
      logic [7:0] v [8];
      int b;
      b = CD_BASE_RST + 8 * j;
      v = '{c, 8'h01, n, 8'($random(seed)), 8'(8 * j), 8'h10, 8'(8 * j), 8'h30};
      for (int i = 0; i < 8; i++) begin
         em[b + i] = v[i];
         ram.mem[b + i] = v[i];
         em[{v[5], v[4]} + i] = 8'($random(seed));
         ram.mem[{v[5], v[4]} + i] = em[{v[5], v[4]} + i];
      end
   endtask
   // one activation of set j, following the chain
   function automatic void model_act(input int j);
      int b, s, d, n, first;
      logic [7:0] c;
      first = 1;
      do begin
         b = CD_BASE_RST + 8 * j;
         c = em[b];
         s = {em[b + 5], em[b + 4]};
         d = {em[b + 7], em[b + 6]};
         em[d] = em[s];
         n = (em[b + 2] + 255) % 256;  // 00h wraps, so 256 runs
         if (first && n == 0 && (!c[0] || c[1])) begin
            en_exp[j] = 1'b0;
         end else if (first && FLAG_CLR_SRC_RST[j]) begin
            clr_exp[j] = 1'b1;
         end
         em[b + 2] = (n == 0 && c[0]) ? em[b + 3] : 8'(n);
         em[b + 4] = 8'(s + c[2]);
         em[b + 5] = 8'((s + c[2]) >> 8);
         em[b + 6] = 8'(d + c[3]);
         em[b + 7] = 8'((d + c[3]) >> 8);
         first = 0;
         j++;
      end while (c[4] && j < 24);
   endfunction
   task automatic mem_chk;
      foreach (em[a]) check("memory byte", ram.mem[a], em[a]);
      rd(ACT_EN_ADDR, en_exp, "enable word");
      check("flag clears", clr_seen, clr_exp);
   endtask
   task automatic enable(input logic [31:0] v);
      en_exp = v;
      wb(1'b1, ACT_EN_ADDR, v);
   endtask
   // hang guard
   initial begin
      repeat (30000) @(posedge clk_i);
      errors++;
      stop_test;
   end
   initial begin
      seed = 32'h12e79fec;
      {cyc, stb, we, slow, adr, wdat, trig, nmi, clr_exp} = 96'h0;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ACT_CTRL_ADDR, 32'h0, "control after reset");
      rd(ACT_EN_ADDR, 32'h0, "enables after reset");
      rd(STATUS_ADDR, 32'h0, "idle status");
      wb(1'b1, 8'h8c, 32'hffff_ffff);
      rd(8'h8c, 32'h0, "unmapped hole");
      wb(1'b1, ACT_CTRL_ADDR, 32'hffff_fffd);
      rd(ACT_CTRL_ADDR, 32'h1, "reserved bit");
      wb(1'b1, ACT_CTRL_ADDR, 32'h0);
      // each event source; clear only after the longest prescaler wait
      for (int e = 0; e < NMI_SRC_NUM; e++) begin
         pulse(24'h0, 4'(1 << e));
         rd(ACT_CTRL_ADDR, 32'h2, "flag set");
         repeat (128) @(posedge clk_i);
         wb(1'b1, ACT_CTRL_ADDR, 32'h0);  // no osc-stop enable here to drop first
         rd(ACT_CTRL_ADDR, 32'h0, "flag cleared");
      end
      pulse(24'h0, 4'h1);
      wb(1'b1, ACT_CTRL_ADDR, 32'h0);
      rd(ACT_CTRL_ADDR, 32'h2, "clear without read");
      wb(1'b1, ACT_CTRL_ADDR, 32'h2);
      rd(ACT_CTRL_ADDR, 32'h2, "one written");
      // flag still up: an enabled trigger must wait
      set_cd(6, 8'h0c, 8'h05);
      enable(32'h00ff_ffff);
      pulse(24'h40, 4'h0);
      repeat (20) @(posedge clk_i);
      check("blocked accesses", accs, 0);
      wb(1'b1, ACT_CTRL_ADDR, 32'h0);
      model_act(6);
      settle;
      mem_chk;
      enable(32'h00ff_ffbf);
      pulse(24'h40, 4'h0);
      repeat (20) @(posedge clk_i);
      check("disabled accesses", accs, 16);
      enable(32'h00ff_ffff);
      // flag rises mid transfer, transfer still completes
      pulse(24'h40, 4'h0);
      repeat (4) @(posedge clk_i);
      rd(STATUS_ADDR, (32'd6 << STAT_CUR_LSB) | (32'd1 << STAT_BUSY_BIT), "busy status");
      pulse(24'h0, 4'h4);
      model_act(6);
      settle;
      mem_chk;
      rd(ACT_CTRL_ADDR, 32'h2, "flag mid transfer");
      wb(1'b1, ACT_CTRL_ADDR, 32'h0);
      // every set, counts of 1, 00h and random, random modes and pacing
      for (int j = 0; j < 24; j++) begin
         slow <= 1'($random(seed));
         set_cd(j, 8'($random(seed)) & 8'h0f,
            j % 3 == 0 ? 8'h01 : j % 3 == 1 ? 8'h00 : 8'($random(seed)));
         pulse(24'(1 << j), 4'h0);
         model_act(j);
         settle;
         mem_chk;
      end
      // chain of two sets from one trigger
      enable(32'h00ff_ffff);
      set_cd(4, 8'h1c, 8'h01);
      set_cd(5, 8'h0c, 8'h01);
      pulse(24'h10, 4'h0);
      model_act(4);
      settle;
      mem_chk;
      // pair arriving while busy, then a pair from idle
      enable(32'h00ff_ffff);
      foreach (pri[k]) set_cd(pri[k], 8'h0c, 8'h09);
      starts.delete();
      pulse(24'h20, 4'h0);
      repeat (3) @(posedge clk_i);
      pulse(24'h208, 4'h0);
      settle;
      pulse(24'h84, 4'h0);
      settle;
      foreach (pri[k]) model_act(pri[k]);
      foreach (pri[k]) check("start order", starts[k], pri[k]);
      mem_chk;
      stop_test;
   end
endmodule
`default_nettype wire

// >>> tb/transfer_activation_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module transfer_activation_control_chk
   import xfer_ctrl_pkg::*;
#(
   parameter logic [23:0] FLAG_CLR_SRC = FLAG_CLR_SRC_RST
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // memory side and peripheral flag clears
   input wire logic [23:0] src_flag_clr_o,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic mem_ack_i
);
   // single domain, so one clocking and one reset cover all
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic wr_done;  // a memory write finished last cycle
   ////////////////////////////////////////////////////////////////////////////////
   // remember write completions, a clear pulse must trail one
   always_ff @(posedge clk_i) begin
      wr_done <= !rst_i && mem_req_o && mem_we_o && mem_ack_i;
   end
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus answer late");
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("bus answer held");
   property p_rd_upper;
      wb_cyc_i && wb_ack_o && !wb_we_i && wb_adr_i == ACT_CTRL_ADDR |-> wb_dat_o[31:2] == 30'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper control bits set");
   property p_req_hold;
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_we_o);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("memory request dropped");
   property p_req_gap;
      mem_req_o && mem_ack_i |=> !mem_req_o;
   endproperty
   a_req_gap: assert property (p_req_gap) else $error("memory request not released");
   property p_clr_pulse;
      src_flag_clr_o != 24'h0 |-> $onehot(src_flag_clr_o) ##1 src_flag_clr_o == 24'h0;
   endproperty
   a_clr_pulse: assert property (p_clr_pulse) else $error("flag clear not a pulse");
   property p_clr_after_wr;
      src_flag_clr_o != 24'h0 |-> wr_done;
   endproperty
   a_clr_after_wr: assert property (p_clr_after_wr) else $error("flag clear early");
   property p_clr_src;
      src_flag_clr_o != 24'h0 |-> (src_flag_clr_o & ~FLAG_CLR_SRC) == 24'h0;
   endproperty
   a_clr_src: assert property (p_clr_src) else $error("flag clear on wrong source");
endmodule
bind transfer_activation_control transfer_activation_control_chk #(
   .FLAG_CLR_SRC(FLAG_CLR_SRC)
) chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
   .src_flag_clr_o, .mem_req_o, .mem_we_o, .mem_ack_i);
`default_nettype wire

// >>> tb/xfer_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module xfer_mem_model (
   // clock, reset and pacing
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   // byte bus from the controller
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [15:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o,
   output logic mem_ack_o
);
   logic [7:0] mem [int];  // sparse store, bench preloads it
   int wait_cnt = 0;  // stall cycles so far
   logic go;  // answer at this edge
   assign go = mem_req_i && !mem_ack_o && !rst_i && (!slow_i || wait_cnt == 3);
   initial mem_rdata_o = 8'h00;
   initial mem_ack_o = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // prompt or three stalls; stale read data toggles so no one relies on it
   always @(posedge clk_i) begin
      mem_ack_o <= go;
      wait_cnt <= (mem_req_i && !go && !mem_ack_o) ? wait_cnt + 1 : 0;
      if (go && mem_we_i) begin
         mem[int'(mem_addr_i)] = mem_wdata_i;
      end
      if (go && !mem_we_i) begin
         mem_rdata_o <= mem.exists(int'(mem_addr_i)) ? mem[int'(mem_addr_i)] : 8'h00;
      end else begin
         mem_rdata_o <= ~mem_rdata_o;
      end
   end
endmodule
`default_nettype wire
